/* hw/slrc_pkg.sv */
// Package: register map, field layout and store constants of the serial register block
package slrc_pkg;
   localparam logic [6:0] ADDR_STORE_CTRL = 7'h17;
   localparam logic [6:0] ADDR_STORE_WDATA_LO = 7'h18;
   localparam logic [6:0] ADDR_STORE_WDATA_HI = 7'h19;
   localparam logic [6:0] ADDR_STORE_RDATA_LO = 7'h28;
   localparam logic [6:0] ADDR_STORE_RDATA_HI = 7'h29;
   localparam logic [6:0] ADDR_SUMMARY2 = 7'h36;
   localparam logic [6:0] ADDR_SUMMARY1 = 7'h37;
   localparam logic [6:0] ADDR_DRV_MODE = 7'h3A;
   localparam int CTRL_FETCH_BIT = 7;
   localparam int CTRL_PROGRAM_BIT = 6;
   localparam int CTRL_ADDR_W = 5;
   localparam int SUM2_DENIED_BIT = 4;
   localparam int SUM2_DONE_BIT = 3;
   localparam int SUM1_SERR_BIT = 6;
   localparam int FRAME_W = 16;
   localparam int FRAME_RD_BIT = 15;
   localparam logic [4:0] STORE_FIRST_WORD = 5'h10;
   localparam logic [4:0] STORE_LAST_WORD = 5'h13;
   localparam logic [15:0] STORE_RST_W10 = 16'h0000;
   localparam logic [15:0] STORE_RST_W11 = 16'h9600;
   localparam logic [15:0] STORE_RST_W12 = 16'h0000;
   localparam logic [15:0] STORE_RST_W13 = 16'h002A;
   localparam int HYST_CH3_LSB = 4;
   localparam int HYST_CH2_LSB = 2;
   localparam int HYST_CH1_LSB = 0;
   localparam int RANGE_CH2_BIT = 7;
   localparam int RANGE_CH1_BIT = 6;
   localparam int RANGE_CH3_BIT = 0;
   localparam int OVR_CH1_LSB = 1;
   localparam int OVR_CH2_LSB = 3;
   localparam int OVR_CH3_LSB = 5;
   localparam logic [1:0] OVR_OFF = 2'h0;
   localparam logic [1:0] OVR_ON = 2'h2;
   localparam int PROGRAM_TIME_NS = 1000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // One received frame handed from the link domain
   typedef struct packed {
      logic rd;
      logic [6:0] addr;
      logic [7:0] data;
   } slrc_frame_t;

   // Store access request to the memory module
   typedef struct packed {
      logic wr;
      logic [4:0] addr;
      logic [15:0] data;
   } slrc_store_req_t;
endpackage

/* hw/slrc_serial_regs.sv */
// Serial slave register interface with fallback-configuration store access
//
// Function
// - Control write with program bit starts store programming at given word.
// - Permitted word: program staged bytes, then set done flag.
// - Denied word: store untouched, denied flag set.
// - Control write with fetch bit starts reading the addressed word.
// - Fetched word appears in low and high read-data registers.
// - Store address is control bits 4:0; words 0x10 to 0x13 used.
// - Word 0x12 high byte: ranges ch2/ch1, hysteresis ch3/ch2/ch1.
// - Word 0x13 low byte: range ch3, overrides ch1-3; default 0x2A.
// - Override code: 00 off, 10 on, 01/11 follow pulse pin.
// - Select active low, clock idles low, output floats when deselected.
// - Sample data on falling clock edge, change on rising edge.
// - Frame: bit 15 read flag, bits 14:8 address, bits 7:0 data.
// - Read frames change no register, except that reading summary 1 clears the serial error flag.
// - Each reply carries first summary register in bits 15:8.
// - Reply low byte: previous read register or newly written value.
// - First command after leaving off mode returns all zeros.
// - Any multiple of 16 bits is accepted for daisy chaining.
// - Bit count not multiple of 16: write ignored, serial error flag set.
// - Data byte of a read frame is ignored.
// - Programming only in store-use mode; LED outputs disabled there.
`timescale 1ns/1ps
`default_nettype none
module slrc_serial_regs
   import slrc_pkg::*;
#(
   parameter int PROG_CYCLES = PROGRAM_CYCLES
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic link_clk_in,
   input wire logic chip_select_n_in,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe_out,
   input wire logic [2:0] pulse_pin_in,
   input wire logic fallback_active_in,
   input wire logic [5:0] summary1_low_in,
   output logic store_use_mode_out,
   output logic [2:0] led_enable_out,
   output logic [7:0] stored_hysteresis_range_byte_out,
   output logic [7:0] stored_pulse_override_byte_out
);
   // ---------------- Link domain ----------------
   logic [15:0] shift_in_r;
   logic [3:0] bit_cnt_r;
   logic any_bit_r;
   logic [15:0] shift_out_r;
   logic [15:0] reply_hold_r;
   logic start_tgl_r;
   logic seen_tgl_r;
   logic [3:0] end_cnt_r;
   slrc_frame_t frame_hold_r;
   logic frame_tgl_r;
   logic [7:0] out_lo_r;
   logic [7:0] out_hi_r;

   // Bit sampling on the falling edge, most significant first
   always_ff @(negedge link_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         shift_in_r <= 16'h0000;
         bit_cnt_r <= 4'h0;
         any_bit_r <= 1'b0;
      end
      else if (!chip_select_n_in)
      begin
         shift_in_r <= {shift_in_r[14:0], serial_data_in};
         bit_cnt_r <= bit_cnt_r + 4'h1;
         any_bit_r <= 1'b1;
      end
   end

   // Reply word is static between frames; taken when select falls
   always_ff @(negedge chip_select_n_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         reply_hold_r <= 16'h0000;
         start_tgl_r <= 1'b0;
      end
      else
      begin
         reply_hold_r <= {out_hi_r, out_lo_r};
         start_tgl_r <= ~start_tgl_r;
      end
   end

   // Serial clock idles outside frames: load at first rising edge, then shift
   always_ff @(posedge link_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         shift_out_r <= 16'h0000;
         seen_tgl_r <= 1'b0;
      end
      else if (seen_tgl_r != start_tgl_r)
      begin
         shift_out_r <= reply_hold_r;
         seen_tgl_r <= start_tgl_r;
      end
      else
         shift_out_r <= {shift_out_r[14:0], shift_in_r[0]};
   end

   assign serial_data_out = chip_select_n_in ? 1'b0 : shift_out_r[15];
   assign serial_data_oe_out = !chip_select_n_in;

   // Frame capture when select rises; serial clock idles low so no link edge then
   always_ff @(posedge chip_select_n_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         frame_hold_r <= '0;
         frame_tgl_r <= 1'b0;
      end
      else if (any_bit_r)
      begin
         frame_hold_r <= slrc_frame_t'(shift_in_r);
         frame_tgl_r <= ~frame_tgl_r;
      end
   end

   logic bad_len_r;
   always_ff @(posedge chip_select_n_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bad_len_r <= 1'b0;
         end_cnt_r <= 4'h0;
      end
      else if (any_bit_r)
      begin
         // Bits of this frame = count difference since the last select rise
         bad_len_r <= (bit_cnt_r != end_cnt_r);
         end_cnt_r <= bit_cnt_r;
      end
   end

   // ---------------- System domain ----------------
   logic tgl_s1_r;
   logic tgl_s2_r;
   logic tgl_s3_r;
   logic cs_s1_r;
   logic cs_s2_r;
   logic frame_evt;
   slrc_frame_t fr;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_s3_r <= 1'b0;
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
      end
      else
      begin
         tgl_s1_r <= frame_tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_s3_r <= tgl_s2_r;
         cs_s1_r <= chip_select_n_in;
         cs_s2_r <= cs_s1_r;
      end
   end

   assign frame_evt = tgl_s2_r ^ tgl_s3_r;
   assign fr = frame_hold_r;

   logic bad_len;
   logic wr_ok;
   assign bad_len = bad_len_r;
   assign wr_ok = frame_evt && !bad_len && !fr.rd;

   logic [7:0] store_ctrl_r;
   logic [7:0] wdata_lo_r;
   logic [7:0] wdata_hi_r;
   logic [7:0] rdata_lo_r;
   logic [7:0] rdata_hi_r;
   logic done_r;
   logic denied_r;
   logic serr_r;
   logic store_use_r;
   logic first_cmd_r;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wdata_lo_r <= 8'h00;
         wdata_hi_r <= 8'h00;
         store_use_r <= 1'b0;
      end
      else if (wr_ok)
      begin
         if (fr.addr == ADDR_STORE_WDATA_LO)
            wdata_lo_r <= fr.data;
         if (fr.addr == ADDR_STORE_WDATA_HI)
            wdata_hi_r <= fr.data;
         if (fr.addr == ADDR_DRV_MODE)
            store_use_r <= fr.data[0];
      end
   end

   // Store sequencer
   typedef enum logic [1:0] {SLRC_IDLE, SLRC_BUSY, SLRC_FINISH} slrc_state_t;
   slrc_state_t state_r;
   logic [15:0] wait_r;
   logic mem_req;
   logic mem_allowed;
   logic [15:0] mem_rdata;
   slrc_store_req_t mem_req_data;
   logic start_prog;
   logic start_fetch;

   assign start_prog = wr_ok && (fr.addr == ADDR_STORE_CTRL) && fr.data[CTRL_PROGRAM_BIT]
      && store_use_r && (state_r == SLRC_IDLE);
   assign start_fetch = wr_ok && (fr.addr == ADDR_STORE_CTRL) && fr.data[CTRL_FETCH_BIT]
      && !fr.data[CTRL_PROGRAM_BIT] && (state_r == SLRC_IDLE);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         store_ctrl_r <= 8'h00;
      else if (wr_ok && fr.addr == ADDR_STORE_CTRL && state_r == SLRC_IDLE)
         store_ctrl_r <= fr.data;
      else if (state_r == SLRC_FINISH)
         store_ctrl_r <= {2'b00, store_ctrl_r[5:0]};
   end

   assign mem_req_data.wr = store_ctrl_r[CTRL_PROGRAM_BIT];
   assign mem_req_data.addr = store_ctrl_r[CTRL_ADDR_W-1:0];
   assign mem_req_data.data = {wdata_hi_r, wdata_lo_r};
   assign mem_req = (state_r == SLRC_BUSY) && (wait_r == 16'h0000);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= SLRC_IDLE;
         wait_r <= 16'h0000;
      end
      else
      begin
         case (state_r)
            SLRC_IDLE:
               if (start_prog || start_fetch)
               begin
                  state_r <= SLRC_BUSY;
                  wait_r <= start_prog ? 16'(PROG_CYCLES) : 16'h0000;
               end
            SLRC_BUSY:
               if (wait_r == 16'h0000)
                  state_r <= SLRC_FINISH;
               else
                  wait_r <= wait_r - 16'h0001;
            SLRC_FINISH:
               state_r <= SLRC_IDLE;
            default:
               state_r <= SLRC_IDLE;
         endcase
      end
   end

   slrc_store_mem #(.ADDR_W(CTRL_ADDR_W)) u_mem (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .req_in(mem_req),
      .req_data_in(mem_req_data),
      .allowed_out(mem_allowed),
      .rdata_out(mem_rdata)
   );

   logic mem_allowed_r;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         mem_allowed_r <= 1'b0;
      else if (mem_req)
         mem_allowed_r <= mem_allowed;
   end

   // Completion flags: set wins over the host clear
   logic clr_flags;
   logic finish;
   assign clr_flags = wr_ok && (fr.addr == ADDR_SUMMARY2);
   assign finish = (state_r == SLRC_FINISH);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         done_r <= 1'b0;
         denied_r <= 1'b0;
      end
      else if (finish)
      begin
         done_r <= mem_allowed_r | done_r & !clr_flags;
         denied_r <= !mem_allowed_r | denied_r & !clr_flags;
      end
      else if (clr_flags)
      begin
         done_r <= 1'b0;
         denied_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rdata_lo_r <= 8'h00;
         rdata_hi_r <= 8'h00;
      end
      else if (finish && !store_ctrl_r[CTRL_PROGRAM_BIT] && mem_allowed_r)
      begin
         rdata_lo_r <= mem_rdata[7:0];
         rdata_hi_r <= mem_rdata[15:8];
      end
   end

   // Serial error flag: set by bad length, cleared by reading summary 1
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         serr_r <= 1'b0;
      else if (frame_evt && bad_len)
         serr_r <= 1'b1;
      else if (frame_evt && fr.rd && fr.addr == ADDR_SUMMARY1)
         serr_r <= 1'b0;
   end

   // Register read mux
   logic [7:0] summary1;
   logic [7:0] summary2;
   logic [7:0] rd_val;
   assign summary1 = {summary1_low_in[5], serr_r, summary1_low_in[4:0], 1'b0} | 8'h00;
   assign summary2 = {3'b000, denied_r, done_r, pulse_pin_in};

   always_comb
   begin
      case (fr.addr)
         ADDR_STORE_CTRL: rd_val = store_ctrl_r;
         ADDR_STORE_WDATA_LO: rd_val = wdata_lo_r;
         ADDR_STORE_WDATA_HI: rd_val = wdata_hi_r;
         ADDR_STORE_RDATA_LO: rd_val = rdata_lo_r;
         ADDR_STORE_RDATA_HI: rd_val = rdata_hi_r;
         ADDR_SUMMARY2: rd_val = summary2;
         ADDR_SUMMARY1: rd_val = summary1;
         ADDR_DRV_MODE: rd_val = {7'h00, store_use_r};
         default: rd_val = 8'h00;
      endcase
   end

   // Reply taken a cycle after the frame so written registers show new contents
   logic frame_evt_d_r;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         frame_evt_d_r <= 1'b0;
      else
         frame_evt_d_r <= frame_evt;
   end

   // Reply for next frame; all zero until the first command has been seen
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         first_cmd_r <= 1'b1;
         out_hi_r <= 8'h00;
         out_lo_r <= 8'h00;
      end
      else if (frame_evt_d_r || (cs_s2_r && !first_cmd_r && state_r != SLRC_IDLE))
      begin
         first_cmd_r <= 1'b0;
         out_hi_r <= summary1;
         out_lo_r <= bad_len ? 8'h00 : rd_val;
      end
   end

   // Fallback configuration decode from stored words
   logic [7:0] ovr_byte;
   assign ovr_byte = u_mem.word_r[3][7:0];
   assign stored_pulse_override_byte_out = ovr_byte;
   assign stored_hysteresis_range_byte_out = u_mem.word_r[2][15:8];
   assign store_use_mode_out = store_use_r;

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++)
      begin : g_ovr
         logic [1:0] code;
         assign code = ovr_byte[OVR_CH1_LSB + 2 * ch +: 2];
         always_comb
         begin
            if (store_use_r)
               led_enable_out[ch] = 1'b0;
            else if (!fallback_active_in)
               led_enable_out[ch] = pulse_pin_in[ch];
            else if (code == OVR_OFF)
               led_enable_out[ch] = 1'b0;
            else if (code == OVR_ON)
               led_enable_out[ch] = 1'b1;
            else
               led_enable_out[ch] = pulse_pin_in[ch];
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* hw/slrc_store_mem.sv */
// Small non-volatile store model with registered read data and write permission check
`timescale 1ns/1ps
`default_nettype none
module slrc_store_mem
   import slrc_pkg::*;
#(
   parameter int ADDR_W = 5
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic req_in,
   input wire slrc_store_req_t req_data_in,
   output logic allowed_out,
   output logic [15:0] rdata_out
);
   logic [15:0] word_r [4];
   logic [1:0] idx;

   assign idx = req_data_in.addr[1:0];
   assign allowed_out = (req_data_in.addr >= STORE_FIRST_WORD) && (req_data_in.addr <= STORE_LAST_WORD);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         word_r[0] <= STORE_RST_W10;
         word_r[1] <= STORE_RST_W11;
         word_r[2] <= STORE_RST_W12;
         word_r[3] <= STORE_RST_W13;
         rdata_out <= 16'h0000;
      end
      else if (req_in && allowed_out)
      begin
         if (req_data_in.wr)
            word_r[idx] <= req_data_in.data;
         else
            rdata_out <= word_r[idx];
      end
      else if (req_in && !req_data_in.wr)
         rdata_out <= 16'h0000;
   end
endmodule
`default_nettype wire

/* verif/slrc_serial_regs_bench.sv */
// Testbench: store programming, fetch and serial framing of the register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module slrc_serial_regs_bench
   import slrc_pkg::*;
;
   logic clk_in, rst_n_in, lclk, csn, sdi, sdo, sdo_oe, fb, smode;
   logic [2:0] pulse, leds;
   logic [5:0] s1 = 6'h15;
   logic [7:0] hyst, ovr, eh, eo;
   logic [31:0] rx;
   logic [4:0] wa [3] = '{5'h12, 5'h13, 5'h13};
   logic [15:0] wv [3] = '{16'hC95A, 16'h0016, 16'h0049};
   int miscompares = 0;
   int total_checks = 0;

   slrc_serial_regs #(.PROG_CYCLES(4)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(lclk),
      .chip_select_n_in(csn), .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe_out(sdo_oe),
      .pulse_pin_in(pulse), .fallback_active_in(fb), .summary1_low_in(s1), .store_use_mode_out(smode),
      .led_enable_out(leds), .stored_hysteresis_range_byte_out(hyst), .stored_pulse_override_byte_out(ovr));
   slrc_spi_host host (.link_clk_out(lclk), .chip_select_n_out(csn), .data_out(sdi), .data_in(sdo));

   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic sx(input logic [15:0] f);
      host.xfer({16'h0, f}, 16, rx);
   endtask

   // Clear flags, start a store access, poll flags under a bound
   task automatic store_op(input logic [7:0] ctl, input logic [1:0] flags);
      int n;
      sx({1'b0, ADDR_SUMMARY2, 8'hFF});
      sx({1'b0, ADDR_STORE_CTRL, ctl});
      sx({1'b1, ADDR_SUMMARY2, 8'h00});
      rx = 32'h0;
      for (n = 0; n < 8 && rx[4:3] == 2'b00; n++)
         sx({1'b1, ADDR_SUMMARY2, 8'h00});
      if (n == 8)
      begin
         miscompares++;
         wrap_up();
      end
      `CHK(rx[4:3], flags)
      sx({1'b1, ADDR_SUMMARY2, 8'h00});
      `CHK(rx[4:3], flags)
   endtask

   function automatic logic [2:0] exp_led(input logic [7:0] o, input logic [2:0] p);
      logic [1:0] c;
      for (int i = 0; i < 3; i++)
      begin
         c = o[2 * i + 1 +: 2];
         exp_led[i] = (c == 2'b00) ? 1'b0 : ((c == 2'b10) ? 1'b1 : p[i]);
      end
   endfunction

   initial
   begin
      rst_n_in = 1'b0;
      fb = 1'b0;
      pulse = 3'h0;
      eh = STORE_RST_W12[15:8];
      eo = STORE_RST_W13[7:0];
      repeat (5) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
      `CHK({hyst, ovr}, {eh, eo})
      sx({1'b1, ADDR_SUMMARY1, 8'h00});
      `CHK(rx[15:0], 16'h0000)
      sx({1'b0, ADDR_DRV_MODE, 8'h01});
      `CHK({rx[15:9], rx[7:1]}, {2{s1[5], 1'b0, s1[4:0]}})
      `CHK(smode, 1'b1)
      $display("reset and reply test done");
      for (int i = 0; i < 3; i++)
      begin
         sx({1'b0, ADDR_DRV_MODE, 8'h01});
         sx({1'b0, ADDR_STORE_WDATA_LO, wv[i][7:0]});
         sx({1'b0, ADDR_STORE_WDATA_HI, wv[i][15:8]});
         `CHK(rx[7:0], wv[i][7:0])
         store_op({3'b010, wa[i]}, 2'b01);
         if (wa[i] == 5'h12)
            eh = wv[i][15:8];
         else
            eo = wv[i][7:0];
         `CHK({hyst, ovr}, {eh, eo})
         sx({1'b0, ADDR_DRV_MODE, 8'h00});
         @(negedge clk_in);
         fb = 1'b1;
         for (int p = 0; p < 8; p += 7)
         begin
            pulse = p[2:0];
            repeat (3) @(negedge clk_in);
            `CHK(leds, exp_led(eo, pulse))
         end
         fb = 1'b0;
      end
      $display("store program test done");
      sx({1'b0, ADDR_DRV_MODE, 8'h01});
      store_op({3'b010, 5'h05}, 2'b10);
      `CHK({hyst, ovr}, {eh, eo})
      store_op({3'b100, 5'h12}, 2'b01);
      sx({1'b1, ADDR_STORE_RDATA_LO, 8'h00});
      sx({1'b1, ADDR_STORE_RDATA_HI, 8'h00});
      `CHK(rx[7:0], 8'h5A)
      sx({1'b1, ADDR_SUMMARY1, 8'h00});
      `CHK(rx[7:0], 8'hC9)
      $display("store denial and fetch test done");
      sx({1'b1, ADDR_STORE_WDATA_LO, 8'hFF});
      sx({1'b1, ADDR_STORE_WDATA_LO, 8'h00});
      `CHK(rx[7:0], 8'h49)
      host.xfer({20'h0, 1'b0, ADDR_STORE_WDATA_LO, 4'hE}, 12, rx);
      sx({1'b1, ADDR_STORE_WDATA_LO, 8'h00});
      `CHK(rx[14], 1'b1)
      sx({1'b1, ADDR_SUMMARY1, 8'h00});
      `CHK(rx[7:0], 8'h49)
      $display("read-only and length test done");
      host.xfer({16'hA5C3, 1'b0, ADDR_STORE_WDATA_LO, 8'h3C}, 32, rx);
      `CHK(rx[15:0], 16'hA5C3)
      sx({1'b1, ADDR_STORE_WDATA_LO, 8'h00});
      sx({1'b1, ADDR_SUMMARY1, 8'h00});
      `CHK(rx[7:0], 8'h3C)
      $display("chained frame test done");
      wrap_up();
   end
endmodule
`default_nettype wire

/* verif/slrc_serial_regs_sva.sv */
// Checker: port-level assertions of the serial register block
`timescale 1ns/1ps
`default_nettype none
module slrc_serial_regs_sva
   import slrc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic link_clk_in,
   input wire logic chip_select_n_in,
   input wire logic serial_data_out,
   input wire logic serial_data_oe_out,
   input wire logic [2:0] pulse_pin_in,
   input wire logic fallback_active_in,
   input wire logic store_use_mode_out,
   input wire logic [2:0] led_enable_out,
   input wire logic [7:0] stored_pulse_override_byte_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_idle;
      chip_select_n_in [*3];
   endsequence
   sequence s_busy;
      !chip_select_n_in [*3];
   endsequence
   // Fallback settled: inputs of the override path steady
   sequence s_limp;
      (fallback_active_in && !store_use_mode_out && $stable(stored_pulse_override_byte_out)
         && $stable(pulse_pin_in)) [*2];
   endsequence

   a_oe_idle: assert property (s_idle |-> !serial_data_oe_out)
      else $error("drive enable high while deselected");
   a_oe_busy: assert property (s_busy |-> serial_data_oe_out)
      else $error("drive enable low while selected");
   a_sdo_idle_low: assert property (s_idle |-> !serial_data_out)
      else $error("serial out not low while deselected");
   a_sdo_rise_only: assert property (!chip_select_n_in && $past(!chip_select_n_in)
      && $changed(serial_data_out) |-> $rose(link_clk_in))
      else $error("serial out changed off a rising link edge");
   a_leds_store_off: assert property (store_use_mode_out [*2] |-> led_enable_out == 3'h0)
      else $error("led enabled in store-use mode");

   for (genvar c = 0; c < 3; c++)
   begin : g_ch
      a_ovr_off: assert property (s_limp ##0 (stored_pulse_override_byte_out[2*c+1 +: 2] == OVR_OFF)
         |-> !led_enable_out[c])
         else $error("forced-off channel enabled");
      a_ovr_on: assert property (s_limp ##0 (stored_pulse_override_byte_out[2*c+1 +: 2] == OVR_ON)
         |-> led_enable_out[c])
         else $error("forced-on channel disabled");
      a_ovr_follow: assert property (s_limp ##0 stored_pulse_override_byte_out[2*c+1]
         |-> led_enable_out[c] == pulse_pin_in[c])
         else $error("channel not following pulse pin");
   end
endmodule

bind slrc_serial_regs slrc_serial_regs_sva u_sva (.clk_in, .rst_n_in, .link_clk_in, .chip_select_n_in,
   .serial_data_out, .serial_data_oe_out, .pulse_pin_in, .fallback_active_in, .store_use_mode_out,
   .led_enable_out, .stored_pulse_override_byte_out);
`default_nettype wire

/* verif/slrc_spi_host.sv */
// Partner: serial host model framing accesses on its own link clock
`timescale 1ns/1ps
`default_nettype none
module slrc_spi_host
(
   output logic link_clk_out,
   output logic chip_select_n_out,
   output logic data_out,
   input wire logic data_in
);
   initial
   begin
      link_clk_out = 1'b0;
      chip_select_n_out = 1'b1;
      data_out = 1'b0;
   end

   // Clock runs only inside the frame; 80 ns period
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0;
      #13;
      chip_select_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         #20;
         link_clk_out = 1'b1;
         data_out = tx[i];
         #40;
         link_clk_out = 1'b0;
         rx = {rx[30:0], data_in};
         #20;
      end
      // Released line shows the inverse of its last bit
      data_out = ~data_out;
      #20;
      chip_select_n_out = 1'b1;
      #1103;
   endtask
endmodule
`default_nettype wire
